//--- hw/pot_nv_store.sv
// holds the shared constants package and the nonvolatile stored-position bank.
// assumes one system clock with an active-low asynchronous reset and a clock enable;
// write requests come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------------------
package pot_pkg;
  localparam int POS_W = 10;
  localparam int NUM_STORED = 4;
  localparam int SEL_W = 2;
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam int RD_W = 16;
  localparam int CLK_PERIOD_NS = 40;
  // bit counts within a frame
  localparam logic [CNT_W-1:0] CNT_SHORT = 6'h10;
  localparam logic [CNT_W-1:0] CNT_LONG = 6'h20;
  localparam logic [CNT_W-1:0] CNT_OVER = 6'h21;
  localparam logic [CNT_W-1:0] CNT_LAST_ID = 6'h0F;
  // identification byte layout
  localparam int ID_RW_BIT = 0;
  localparam int ID_ADDR_BIT = 1;
  localparam logic [1:0] ID_ZERO_BITS = 2'h0;
  // instruction byte layout and opcodes
  localparam int INS_OP_LSB = 5;
  localparam int INS_ZERO_BIT = 4;
  localparam logic [2:0] OP_WIPER_RD = 3'h4;
  localparam logic [2:0] OP_WIPER_WR = 3'h5;
  localparam logic [2:0] OP_STORED_RD = 3'h5;
  localparam logic [2:0] OP_STORED_WR = 3'h6;
  localparam logic [2:0] OP_COPY_TO_WIPER = 3'h6;
  localparam logic [2:0] OP_COPY_TO_STORED = 3'h7;
  localparam logic [2:0] OP_STATUS_RD = 3'h2;
  localparam logic [3:0] PTR_ZERO = 4'h0;
  localparam logic [3:0] PTR_STATUS = 4'h1;
  localparam logic [1:0] PTR_LOW_ZERO = 2'h0;
  // reset value and answer word padding
  localparam logic [POS_W-1:0] POS_RESET = 10'h000;
  localparam logic [5:0] PAD_BITS = 6'h00;
  localparam logic [14:0] STATUS_PAD = 15'h0000;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_WIPER_RD,
    CMD_WIPER_WR,
    CMD_STORED_RD,
    CMD_STORED_WR,
    CMD_COPY_TO_WIPER,
    CMD_COPY_TO_STORED,
    CMD_STATUS_RD
  } cmd_t;

  // decode of the two header bytes; used at both ends of the clock crossing
  function automatic cmd_t decode_cmd(input logic [7:0] id, input logic [7:0] ins,
                                      input logic addr, input logic [3:0] type_code);
    cmd_t c;
    logic [2:0] op;
    logic [3:0] ptr;
    logic ptr_ok;
    c = CMD_NONE;
    op = ins[7:INS_OP_LSB];
    ptr = ins[3:0];
    ptr_ok = !ins[INS_ZERO_BIT] && (ptr[1:0] == PTR_LOW_ZERO);
    if (id[7:4] == type_code && id[3:2] == ID_ZERO_BITS && id[ID_ADDR_BIT] == addr) begin
      if (id[ID_RW_BIT]) begin
        if (op == OP_WIPER_RD && !ins[INS_ZERO_BIT] && ptr == PTR_ZERO)
          c = CMD_WIPER_RD;
        else if (op == OP_STORED_RD && ptr_ok)
          c = CMD_STORED_RD;
        else if (op == OP_COPY_TO_WIPER && ptr_ok)
          c = CMD_COPY_TO_WIPER;
        else if (op == OP_STATUS_RD && ptr == PTR_STATUS)
          c = CMD_STATUS_RD;
      end else begin
        if (op == OP_WIPER_WR && !ins[INS_ZERO_BIT] && ptr == PTR_ZERO)
          c = CMD_WIPER_WR;
        else if (op == OP_STORED_WR && ptr_ok)
          c = CMD_STORED_WR;
        else if (op == OP_COPY_TO_STORED && ptr_ok)
          c = CMD_COPY_TO_STORED;
      end
    end
    return c;
  endfunction
endpackage

// ----------------------------------------------------------------------------
// stored-position bank with write-cycle timer
// ----------------------------------------------------------------------------
module pot_nv_store #(
  parameter int WRITE_CYCLES = 125000
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_wr_req,
  input wire logic [pot_pkg::SEL_W-1:0] i_wr_sel,
  input wire logic [pot_pkg::POS_W-1:0] i_wr_data,
  output logic [pot_pkg::NUM_STORED*pot_pkg::POS_W-1:0] o_stored,
  output logic o_busy
);
  localparam logic [31:0] LAST_CYCLE = 32'(WRITE_CYCLES - 1);

  logic [31:0] timer_r;
  logic accept;

  // a request during a running cycle is dropped; caller also gates on busy
  assign accept = i_wr_req && !o_busy;

  // one register per entry, loaded when its write is accepted
  genvar g;
  generate
    for (g = 0; g < pot_pkg::NUM_STORED; g++) begin : g_entry
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_stored[g*pot_pkg::POS_W +: pot_pkg::POS_W] <= pot_pkg::POS_RESET;
        end else if (i_ce && accept && i_wr_sel == g[pot_pkg::SEL_W-1:0]) begin
          o_stored[g*pot_pkg::POS_W +: pot_pkg::POS_W] <= i_wr_data;
        end
      end
    end
  endgenerate

  // write-in-progress window: busy for WRITE_CYCLES clocks after acceptance
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
      timer_r <= '0;
    end else if (i_ce) begin
      if (accept) begin
        o_busy <= 1'b1;
        timer_r <= '0;
      end else if (o_busy) begin
        if (timer_r == LAST_CYCLE) begin
          o_busy <= 1'b0;
        end
        timer_r <= timer_r + 32'h1;
      end
    end
  end
endmodule

`default_nettype wire

//--- hw/pot_serial_command_frames.sv
// serial command front end of a digital potentiometer: frame decode, wiper and
// stored-position registers, write status. assumes a mode-0 serial host (data
// sampled on the rising serial clock, shifted out on the falling one) and a
// system clock that runs freely while the serial clock stops between frames.


`timescale 1ns/1ps
`default_nettype none

module pot_serial_command_frames #(
  parameter logic [3:0] TYPE_CODE = 4'hA, // arbitrary value, not a real part code
  parameter int NV_WRITE_NS = 5000000
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_addr_pin,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  output logic [pot_pkg::POS_W-1:0] o_wiper_pos,
  output logic o_write_busy
);
  localparam int NV_WRITE_CYCLES = NV_WRITE_NS / pot_pkg::CLK_PERIOD_NS;
  localparam int SW = pot_pkg::POS_W;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic link_rst_n;
  logic [pot_pkg::CNT_W-1:0] cnt_r;
  logic [pot_pkg::CNT_W-1:0] cnt_nxt;
  logic [pot_pkg::FRAME_BITS-1:0] shift_r;
  logic [pot_pkg::FRAME_BITS-1:0] shift_nxt;
  logic [pot_pkg::CNT_W-1:0] snap_cnt_r;
  logic [pot_pkg::FRAME_BITS-1:0] snap_word_r;
  logic frame_tgl_r;
  logic busy_l1_r;
  logic busy_l2_r;
  logic [pot_pkg::RD_W-1:0] rd_word_r;
  logic rd_act_r;
  pot_pkg::cmd_t link_cmd;
  logic [4:0] out_idx;

  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic last_tgl_r;
  logic addr_s1_r;
  logic addr_s2_r;
  logic frame_end;
  logic [7:0] hdr_id;
  logic [7:0] hdr_ins;
  pot_pkg::cmd_t sys_cmd;
  logic [pot_pkg::SEL_W-1:0] sys_sel;
  logic [SW-1:0] sys_data;
  logic long_ok;
  logic short_ok;
  logic nv_req;
  logic [SW-1:0] nv_data;
  logic [pot_pkg::NUM_STORED*SW-1:0] stored;
  logic nv_busy;

  // --------------------------------------------------------------------------
  // link domain: serial clock, framed by select
  // --------------------------------------------------------------------------
  // frame timing, counted in rising serial clock edges: 1-8 carry the
  // identification byte, 9-16 the instruction byte, 17-32 the data half.
  // an answer starts on the falling edge after the sixteenth rise, so the
  // host sees its first bit at rise seventeen.
  // select high clears the per-frame shifter; snapshots below survive it
  assign link_rst_n = i_nrst & ~i_cs_n;

  // bit counter saturates one past a long frame so overlong frames are seen
  assign cnt_nxt = (cnt_r == pot_pkg::CNT_OVER) ? cnt_r : cnt_r + 6'h01;
  assign shift_nxt = {shift_r[pot_pkg::FRAME_BITS-2:0], i_si};

  // shift in the frame, first bit ends up highest
  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_r <= '0;
      shift_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
    end
  end

  // snapshot of the frame so far; read by the system side only after
  // select has risen, when the serial clock stands still
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      snap_cnt_r <= '0;
      snap_word_r <= '0;
      frame_tgl_r <= 1'b0;
    end else begin
      snap_cnt_r <= cnt_nxt;
      snap_word_r <= shift_nxt;
      if (cnt_r == '0) begin
        frame_tgl_r <= ~frame_tgl_r; // marks a fresh frame
      end
    end
  end

  // busy flag resynchronised onto the serial clock; fifteen edges pass before its use at the sixteenth
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_l1_r <= 1'b0;
      busy_l2_r <= 1'b0;
    end else begin
      busy_l1_r <= nv_busy;
      busy_l2_r <= busy_l1_r;
    end
  end

  // header decode as the sixteenth bit arrives; address pin copy is static
  assign link_cmd = pot_pkg::decode_cmd(shift_r[14:7], shift_nxt[7:0], addr_s2_r, TYPE_CODE);

  // pick the answer word once the header is in
  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_word_r <= '0;
      rd_act_r <= 1'b0;
    end else if (cnt_r == pot_pkg::CNT_LAST_ID) begin
      rd_act_r <= 1'b1;
      case (link_cmd)
        pot_pkg::CMD_WIPER_RD: begin
          rd_word_r <= {pot_pkg::PAD_BITS, o_wiper_pos};
        end
        pot_pkg::CMD_STORED_RD: begin
          rd_word_r <= {pot_pkg::PAD_BITS, stored[shift_nxt[3:2]*SW +: SW]};
        end
        pot_pkg::CMD_STATUS_RD: begin
          rd_word_r <= {pot_pkg::STATUS_PAD, busy_l2_r};
        end
        default: begin
          rd_act_r <= 1'b0;
          rd_word_r <= '0;
        end
      endcase
    end
  end

  // output bit for the current position, counted from the frame end
  assign out_idx = 5'(pot_pkg::CNT_LONG - 6'h01 - cnt_r);

  // answer shifted out on the falling edge, most significant bit first
  always_ff @(negedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else if (rd_act_r && cnt_r >= pot_pkg::CNT_SHORT && cnt_r < pot_pkg::CNT_LONG) begin
      o_so <= rd_word_r[out_idx[3:0]];
      o_so_oe <= 1'b1;
    end else begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // system domain: synchronisers
  // --------------------------------------------------------------------------
  // select, frame toggle and address pin each pass two flops
  // select edges drive execution, so a metastable select must settle first
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      addr_s1_r <= 1'b0;
      addr_s2_r <= 1'b0;
    end else if (i_ce) begin
      cs_s1_r <= i_cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      tgl_s1_r <= frame_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      addr_s1_r <= i_addr_pin;
      addr_s2_r <= addr_s1_r;
    end
  end

  // a frame ends on select rising, and only if clock edges were seen in it
  assign frame_end = cs_s2_r && !cs_d_r && (tgl_s2_r != last_tgl_r);

  // toggle reference follows the synchronised toggle whenever select is seen
  // high, not only at frame end: a frame whose end was missed while the clock
  // enable was low must not leave the reference one toggle behind, which
  // would make the next good frame look empty. the toggle of a new frame
  // reaches tgl_s2_r no earlier than its select low reaches cs_s2_r, so the
  // reference never swallows it.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      last_tgl_r <= 1'b0;
    end else if (i_ce && cs_s2_r) begin
      last_tgl_r <= tgl_s2_r;
    end
  end

  // --------------------------------------------------------------------------
  // system domain: command execution at frame end
  // --------------------------------------------------------------------------
  // commands act only once select has been seen high through the
  // synchronisers; until then the serial clock may still move the snapshot.
  // lengths are checked here rather than on the link side so that a frame
  // cut short or run long changes nothing at all.
  // header sits at the top of a long frame, at the bottom of a short one
  assign long_ok = (snap_cnt_r == pot_pkg::CNT_LONG);
  assign short_ok = (snap_cnt_r == pot_pkg::CNT_SHORT);
  assign hdr_id = long_ok ? snap_word_r[31:24] : snap_word_r[15:8];
  assign hdr_ins = long_ok ? snap_word_r[23:16] : snap_word_r[7:0];
  assign sys_cmd = pot_pkg::decode_cmd(hdr_id, hdr_ins, addr_s2_r, TYPE_CODE);
  assign sys_sel = hdr_ins[3:2];
  assign sys_data = snap_word_r[SW-1:0];

  // stored writes: data frame or copy from the wiper; any other length discards
  always_comb begin
    nv_req = 1'b0;
    nv_data = sys_data;
    if (frame_end && !nv_busy) begin
      case (sys_cmd)
        pot_pkg::CMD_STORED_WR: begin
          nv_req = long_ok;
        end
        pot_pkg::CMD_COPY_TO_STORED: begin
          nv_req = short_ok;
          nv_data = o_wiper_pos;
        end
        default: begin
          nv_req = 1'b0;
        end
      endcase
    end
  end

  // wiper position register: written at select release only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wiper_pos <= pot_pkg::POS_RESET;
    end else if (i_ce && frame_end) begin
      case (sys_cmd)
        pot_pkg::CMD_WIPER_WR: begin
          if (long_ok) begin
            o_wiper_pos <= sys_data;
          end
        end
        pot_pkg::CMD_COPY_TO_WIPER: begin
          if (short_ok) begin
            o_wiper_pos <= stored[sys_sel*SW +: SW];
          end
        end
        default: begin
          o_wiper_pos <= o_wiper_pos;
        end
      endcase
    end
  end

  // status flag mirrors the nonvolatile cycle, already a flop
  // one clock behind the bank's own flag; status reads use the link-side copy
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_write_busy <= 1'b0;
    end else if (i_ce) begin
      o_write_busy <= nv_busy;
    end
  end

  // --------------------------------------------------------------------------
  // stored-position bank
  // --------------------------------------------------------------------------
  // the bank takes a request only while idle; a write that arrives during
  // a running cycle is dropped, and the host is expected to poll the flag
  pot_nv_store #(
    .WRITE_CYCLES(NV_WRITE_CYCLES)
  ) u_store (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_wr_req(nv_req),
    .i_wr_sel(sys_sel),
    .i_wr_data(nv_data),
    .o_stored(stored),
    .o_busy(nv_busy)
  );
endmodule

`default_nettype wire

//--- dv/pot_host_model.sv
// serial host model: drives select, serial clock and data for one frame per call.
// assumes the bench leaves select high between calls; a released serial out reads high.
`timescale 1ns/1ps
`default_nettype none
module pot_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  // ----
  // idle levels
  // ----
  initial begin
    o_sck = 1'h0; // clock stands still outside frames
    o_cs_n = 1'h1;
    o_si = 1'h0;
  end

  // ----
  // frame driver, msb first, data sampled on the rising clock
  // ----
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    #5 o_cs_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      o_si = tx[i];
      #16 o_sck = 1'h1;
      rx = {rx[30:0], i_so_oe ? i_so : 1'h1}; // no pull: idle must not pass as data
      #16 o_sck = 1'h0;
    end
    #16 o_cs_n = 1'h1;
    o_si = ~o_si; // released line must not show the last bit
    #240;
  endtask
endmodule
`default_nettype wire

//--- dv/pot_frames_checker.sv
// checker for the serial command front end; sees only its top ports.
// assumes the system clock enable stays high while busy lengths are judged.
`timescale 1ns/1ps
`default_nettype none
module pot_frames_checker #(
  parameter int NV_WRITE_NS = 5000000
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic [pot_pkg::POS_W-1:0] o_wiper_pos,
  input wire logic o_write_busy
);
  localparam int BUSY_CLKS = NV_WRITE_NS / pot_pkg::CLK_PERIOD_NS;
  logic [31:0] busy_cnt_r;

  // length of the current busy stretch, in clocks
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= o_write_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
  end

  // ----
  // properties
  // ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_oe_idle: assert property (i_cs_n |-> !o_so_oe)
    else $error("serial out driven outside a frame");
  chk_so_quiet: assert property (!o_so_oe |-> !o_so)
    else $error("serial out not low while released");
  chk_wiper_late: assert property (!$stable(o_wiper_pos) |-> $past(i_cs_n, 1) && $past(i_cs_n, 2))
    else $error("wiper moved before frame end was seen");
  chk_frame_hold: assert property (!i_cs_n [*2] |-> $stable(o_wiper_pos))
    else $error("wiper moved inside a frame");
  chk_busy_start: assert property ($rose(o_write_busy) |-> $past(i_cs_n, 3))
    else $error("busy rose without a finished frame");
  chk_busy_len: assert property ($fell(o_write_busy) |-> busy_cnt_r == BUSY_CLKS)
    else $error("write cycle length wrong");
  chk_busy_bound: assert property (o_write_busy |-> busy_cnt_r < BUSY_CLKS)
    else $error("write cycle too long");
  chk_reset_vals: assert property (!$past(i_nrst) |-> o_wiper_pos == 10'h000 && !o_write_busy)
    else $error("wrong values after reset");

  cover property ($rose(o_write_busy));
  cover property ($rose(o_so_oe));
  cover property (!$stable(o_wiper_pos));
endmodule

bind pot_serial_command_frames pot_frames_checker #(.NV_WRITE_NS(NV_WRITE_NS)) u_pot_frames_checker (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_cs_n(i_cs_n),
  .o_so(o_so),
  .o_so_oe(o_so_oe),
  .o_wiper_pos(o_wiper_pos),
  .o_write_busy(o_write_busy)
);
`default_nettype wire

//--- dv/pot_serial_command_frames_test.sv
// self-checking bench for the serial command front end.
// assumes the host model in its own file; the write cycle is shortened to 50 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module pot_serial_command_frames_test;
  localparam logic [3:0] TC = 4'h6; // arbitrary type code
  logic i_clk, i_nrst, i_ce, i_addr_pin, sck, cs_n, si, so, so_oe, busy;
  logic [pot_pkg::POS_W-1:0] wiper, v;
  logic [pot_pkg::POS_W-1:0] st_m [4];
  logic [31:0] rx;
  int seed = 29;
  int n_errors = 0;
  int total_checks = 0;

  pot_serial_command_frames #(.TYPE_CODE(TC), .NV_WRITE_NS(2000)) u_pot_serial_command_frames (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr_pin(i_addr_pin), .i_sck(sck),
    .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_wiper_pos(wiper),
    .o_write_busy(busy));
  pot_host_model u_pot_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so),
    .i_so_oe(so_oe));

  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end

  // ----
  // frame helpers
  // ----
  function automatic logic [7:0] id_b(input logic rw, input logic a);
    return {TC, 2'h0, a, rw};
  endfunction
  function automatic logic [7:0] ins_b(input logic [2:0] op, input logic [1:0] sel);
    return {op, 1'h0, sel, 2'h0};
  endfunction
  // short frames keep only the leading bits of the full 32-bit word
  task automatic cmd(input logic rw, input logic [2:0] op, input logic [1:0] sel,
                     input logic [9:0] d, input int n, input logic a);
    u_pot_host_model.xfer(n, {id_b(rw, a), ins_b(op, sel), 6'h2A, d} >> (32 - n), rx);
  endtask
  task automatic status(input logic b);
    u_pot_host_model.xfer(32, {id_b(1'h1, i_addr_pin), 8'h41, 16'h0}, rx);
    `CHECK(rx[7:0], {7'h00, b})
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 200 && busy !== 1'h0; i++) @(negedge i_clk);
    `CHECK(busy, 1'h0)
  endtask
  task automatic summarize;
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  initial begin
    i_nrst = 1'h0;
    i_ce = 1'h1;
    i_addr_pin = 1'h0;
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'h1;
    repeat (4) @(posedge i_clk);
    // corner values first to expose bit order
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 10'h3FF : (i == 1) ? 10'h001 : 10'($random(seed));
      cmd(1'h0, 3'h5, 2'h0, v, 32, i_addr_pin);
      `CHECK(wiper, v)
      cmd(1'h1, 3'h4, 2'h0, 10'h000, 32, i_addr_pin);
      `CHECK(rx[9:0], v)
    end
    for (int s = 0; s < 4; s++) begin
      st_m[s] = 10'($random(seed));
      cmd(1'h0, 3'h6, 2'(s), st_m[s], 32, i_addr_pin);
      status(1'h1);
      wait_idle();
      status(1'h0);
    end
    for (int s = 0; s < 4; s++) begin
      cmd(1'h1, 3'h5, 2'(s), 10'h000, 32, i_addr_pin);
      `CHECK(rx[9:0], st_m[s])
    end
    cmd(1'h1, 3'h6, 2'h2, 10'h000, 16, i_addr_pin);
    `CHECK(wiper, st_m[2])
    v = 10'($random(seed));
    cmd(1'h0, 3'h5, 2'h0, v, 32, i_addr_pin);
    cmd(1'h0, 3'h7, 2'h1, 10'h000, 16, i_addr_pin);
    `CHECK(busy, 1'h1)
    wait_idle();
    cmd(1'h1, 3'h5, 2'h1, 10'h000, 32, i_addr_pin);
    `CHECK(rx[9:0], v)
    // refused frames leave the wiper alone
    cmd(1'h0, 3'h5, 2'h0, ~v, 32, ~i_addr_pin);
    `CHECK(wiper, v)
    cmd(1'h1, 3'h4, 2'h0, 10'h000, 32, ~i_addr_pin);
    `CHECK(rx, 32'hFFFFFFFF)
    cmd(1'h0, 3'h5, 2'h0, ~v, 31, i_addr_pin);
    `CHECK(wiper, v)
    cmd(1'h1, 3'h6, 2'h3, 10'h000, 24, i_addr_pin);
    `CHECK(wiper, v)
    u_pot_host_model.xfer(32, {~TC, 2'h0, i_addr_pin, 1'h0, 8'hA0, 6'h00, ~v}, rx);
    `CHECK(wiper, v)
    @(posedge i_clk);
    i_addr_pin <= 1'h1;
    repeat (3) @(posedge i_clk);
    cmd(1'h0, 3'h5, 2'h0, ~v, 32, 1'h1);
    `CHECK(wiper, ~v)
    // second reset in mid-run, cutting a running write cycle
    cmd(1'h0, 3'h6, 2'h3, ~v, 32, 1'h1);
    `CHECK(busy, 1'h1)
    @(posedge i_clk);
    i_nrst <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'h1;
    @(negedge i_clk);
    `CHECK(wiper, pot_pkg::POS_RESET)
    `CHECK(busy, 1'h0)
    repeat (3) @(posedge i_clk);
    cmd(1'h1, 3'h5, 2'h3, 10'h000, 32, 1'h1);
    `CHECK(rx[9:0], pot_pkg::POS_RESET)
    summarize();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
